// >>> core/pepw_ctrl.sv
// PCIe endpoint power, wake and window control.
// Assumes MAC status pins are asynchronous; DMA strobes share clk_in.
//
// How it works
// [RULE_01] Software sets upper window address bits
// [RULE_02] Software sets lower bits, at most c000
// [RULE_03] Enabled region redirects upper gigabyte
// [RULE_04] Software stops frame DMA before reprogramming
// [RULE_05] Only D0, D1, D3 states supported
// [RULE_06] Power changes never touch switch core
// [RULE_07] Aux config three forces aux detection
// [RULE_08] Power state readable, change sets sticky
// [RULE_09] Event interrupts only when enabled
// [RULE_10] Identity nonzero when interrupt asserted
// [RULE_11] PME only if enabled and powered down
// [RULE_12] Outbound requests from masters trigger PME
// [RULE_13] Enabled irq changes wake unless disabled
// [RULE_14] D3 without beacon disable sends beacon
// [RULE_15] Beacon disable drives WAKE instead
// [RULE_16] WAKE level follows polarity bit
// [RULE_17] WAKE drive scheme set by enable bit
// [RULE_18] MAC reset leaves rest running
// [RULE_19] Host saves state, resets, waits, restores
// [RULE_20] Soft chip reset reinitialises device
// [RULE_21] Sticky bit cleared by writing one
`timescale 1ns/1ps
module pepw_ctrl #(
   parameter int RST_CYCLES = pepw_pkg::CHIP_RST_CYC
) (
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   input  wire logic [7:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   // MAC side, asynchronous
   input  wire logic [1:0]  power_state_field_in,
   input  wire logic        pme_enable_in,
   input  wire logic        mac_reset_in,
   // Outbound traffic, same clock
   input  wire logic [31:0] frame_dma_engine_addr_in,
   input  wire logic        frame_dma_engine_req_in,
   input  wire logic        system_bus_masters_req_in,
   input  wire logic [1:0]  outbound_irq_status_in,
   input  wire logic [1:0]  outbound_irq_enable_in,
   // Results
   output logic             xlate_hit_out,
   output logic [63:0]      xlate_addr_out,
   output logic             aux_power_detect_out,
   output logic             cpu_irq_out,
   output logic             pme_request_out,
   output logic             beacon_out,
   output logic             wake_o_out,
   output logic             wake_oe_out,
   output logic             chip_reset_out
);
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic [31:0] xlate_target_upper;
   logic [15:0] xlate_target_lower;
   logic        xlate_region_enable;
   logic [2:0]  link_pcs_cfg;
   logic        endpoint_sticky_events;
   logic        endpoint_event_enables;
   logic [1:0]  aux_cfg;
   logic        irq_wakeup_disable;
   logic [1:0]  pm_sync;
   logic        pme_en_sync;
   logic        mac_rst_sync;
   logic [1:0]  pm_prev;
   logic        pm_changed;
   logic        wr_fire;
   logic        rd_fire;
   logic [31:0] wmask;
   logic        soft_req;
   logic        chip_busy;
   logic        powered_down;
   logic        wake_trigger;
   logic [1:0]  irq_prev;
   logic [31:0] next_rdata;
   logic        next_rerr;
   logic        wake_active;
   pepw_pkg::pepw_wake_t wake_state;

   pepw_sync #(.W(4)) u_sync (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .async_in ({mac_reset_in, pme_enable_in, power_state_field_in}),
      .sync_out ({mac_rst_sync, pme_en_sync, pm_sync})
   );

   // Write address and data in either order
   assign wr_fire = aw_held && w_held && !s_axi_bvalid_out;
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_in;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end
   assign s_axi_awready_out = !aw_held;
   assign s_axi_wready_out  = !w_held;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out  <= pepw_pkg::AXI_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_out <= 1'b1;
         s_axi_bresp_out  <= (aw_addr > pepw_pkg::REG_SOFT_RST ||
                              aw_addr[1:0] != 2'h0) ?
                             pepw_pkg::AXI_SLVERR : pepw_pkg::AXI_OKAY;
      end else if (s_axi_bready_in) begin
         s_axi_bvalid_out <= 1'b0;
      end
   end

   genvar b;
   for (b = 0; b < 4; b++) begin : g_strb
      assign wmask[8*b +: 8] = {8{w_strb[b]}};
   end

   // Software-written configuration
   always_ff @(posedge clk_in) begin
      if (srst_in || chip_busy) begin
         xlate_target_upper  <= 32'h0000_0000;
         xlate_target_lower  <= 16'h0000;
         xlate_region_enable <= 1'b0;
         link_pcs_cfg        <= 3'h0;
         endpoint_event_enables <= 1'b0;
         aux_cfg             <= 2'h0;
         irq_wakeup_disable  <= 1'b0;
      end else if (wr_fire) begin
         case (aw_addr)
            pepw_pkg::REG_XLATE_UPPER: xlate_target_upper <=
               (xlate_target_upper & ~wmask) | (w_data & wmask);
            pepw_pkg::REG_XLATE_LOWER: if (w_strb[0] && w_strb[1]) begin
               xlate_target_lower <= w_data[15:0];
            end
            pepw_pkg::REG_XLATE_CFG2: if (w_strb[0]) begin
               xlate_region_enable <= w_data[pepw_pkg::XLATE_ENA_BIT];
            end
            pepw_pkg::REG_LINK_PCS_CFG: if (w_strb[0]) begin
               link_pcs_cfg <= w_data[2:0];
            end
            pepw_pkg::REG_EVENT_ENA: if (w_strb[0]) begin
               endpoint_event_enables <= w_data[pepw_pkg::PM_EVENT_BIT];
            end
            pepw_pkg::REG_AUX_CFG: if (w_strb[0]) begin
               aux_cfg <= w_data[1:0];
            end
            pepw_pkg::REG_IRQ_COMMON: if (w_strb[0]) begin
               irq_wakeup_disable <= w_data[pepw_pkg::IRQ_WAKE_DIS];
            end
            default: begin
            end
         endcase
      end
   end

   // [RULE_20] Soft reset request
   assign soft_req = wr_fire && aw_addr == pepw_pkg::REG_SOFT_RST &&
                     w_strb[0] && w_data[pepw_pkg::SOFT_CHIP_BIT];
   pepw_reset_pulse #(.CYCLES(RST_CYCLES)) u_rst (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .start_in (soft_req),
      .busy_out (chip_busy)
   );
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         chip_reset_out <= 1'b0;
      end else begin
         chip_reset_out <= chip_busy;
      end
   end

   // [RULE_08] Power state change detect
   // [RULE_18] MAC reset leaves this alone
   assign pm_changed = pm_sync != pm_prev;
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pm_prev <= pepw_pkg::PM_D0;
      end else begin
         pm_prev <= pm_sync;
      end
   end

   // [RULE_21] Sticky set wins over write-one clear
   always_ff @(posedge clk_in) begin
      if (srst_in || chip_busy) begin
         endpoint_sticky_events <= 1'b0;
      end else if (pm_changed) begin
         endpoint_sticky_events <= 1'b1;
      end else if (wr_fire && aw_addr == pepw_pkg::REG_EVENTS &&
                   w_strb[0] && w_data[pepw_pkg::PM_EVENT_BIT]) begin
         endpoint_sticky_events <= 1'b0;
      end
   end

   // [RULE_09] Gated event to CPU; [RULE_06] no core action
   // [RULE_10] Identity reads this flop
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cpu_irq_out <= 1'b0;
      end else begin
         cpu_irq_out <= endpoint_sticky_events && endpoint_event_enables;
      end
   end

   // [RULE_03] Upper gigabyte redirect
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         xlate_hit_out  <= 1'b0;
         xlate_addr_out <= 64'h0;
      end else begin
         xlate_hit_out <= xlate_region_enable && frame_dma_engine_req_in &&
                          frame_dma_engine_addr_in[31:30] == pepw_pkg::WIN_SEL;
         xlate_addr_out <= {xlate_target_upper,
                            xlate_target_lower, 16'h0000} +
                           {34'h0, frame_dma_engine_addr_in[29:0]};
      end
   end

   // [RULE_07] Forced aux power detection
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         aux_power_detect_out <= 1'b0;
      end else begin
         aux_power_detect_out <= aux_cfg == pepw_pkg::AUX_FORCE;
      end
   end

   // [RULE_05] D1 and D3 count as power-down
   assign powered_down = pm_sync == pepw_pkg::PM_D1 ||
                         pm_sync == pepw_pkg::PM_D3;
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         irq_prev <= 2'h0;
      end else begin
         irq_prev <= outbound_irq_status_in;
      end
   end
   // [RULE_12] Outbound requests wake
   // [RULE_13] Enabled interrupt changes wake
   assign wake_trigger = frame_dma_engine_req_in ||
      system_bus_masters_req_in ||
      (!irq_wakeup_disable &&
       |((outbound_irq_status_in ^ irq_prev) & outbound_irq_enable_in));

   // [RULE_11] PME only when enabled and powered down
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         wake_state      <= pepw_pkg::PEPW_WAKE_IDLE;
         pme_request_out <= 1'b0;
      end else begin
         pme_request_out <= 1'b0;
         case (wake_state)
            pepw_pkg::PEPW_WAKE_IDLE:
               if (pme_en_sync && powered_down && wake_trigger) begin
                  wake_state <= pepw_pkg::PEPW_WAKE_PEND;
               end
            pepw_pkg::PEPW_WAKE_PEND: begin
               pme_request_out <= 1'b1;
               wake_state      <= pepw_pkg::PEPW_WAKE_SENT;
            end
            pepw_pkg::PEPW_WAKE_SENT:
               // One PME until power-up, PME disable or MAC reset avoids message storms
               if (!powered_down || !pme_en_sync || mac_rst_sync) begin
                  wake_state <= pepw_pkg::PEPW_WAKE_IDLE;
               end
            default: wake_state <= pepw_pkg::PEPW_WAKE_IDLE;
         endcase
      end
   end
   assign wake_active = wake_state == pepw_pkg::PEPW_WAKE_SENT;

   // [RULE_14] Beacon in D3 unless disabled
   // [RULE_15] WAKE instead when beacon disabled
   // [RULE_16] Polarity applied; [RULE_17] drive scheme
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         beacon_out  <= 1'b0;
         wake_o_out  <= 1'b0;
         wake_oe_out <= 1'b0;
      end else begin
         beacon_out <= pm_sync == pepw_pkg::PM_D3 &&
                       !link_pcs_cfg[pepw_pkg::BEACON_DISABLE_BIT];
         wake_o_out <= (link_pcs_cfg[pepw_pkg::BEACON_DISABLE_BIT] &&
                        wake_active) ^
                       link_pcs_cfg[pepw_pkg::WAKE_OUT_POLARITY_BIT];
         wake_oe_out <= link_pcs_cfg[pepw_pkg::WAKE_OE_BIT] ?
                        (link_pcs_cfg[pepw_pkg::BEACON_DISABLE_BIT] &&
                         wake_active) : 1'b1;
      end
   end

   // Read path
   assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rerr  = 1'b0;
      case (s_axi_araddr_in)
         pepw_pkg::REG_XLATE_UPPER:  next_rdata = xlate_target_upper;
         pepw_pkg::REG_XLATE_LOWER:  next_rdata[15:0] = xlate_target_lower;
         pepw_pkg::REG_XLATE_CFG2:   next_rdata[0] = xlate_region_enable;
         pepw_pkg::REG_PWR_STAT:     next_rdata[1:0] = pm_sync;
         pepw_pkg::REG_LINK_PCS_CFG: next_rdata[2:0] = link_pcs_cfg;
         pepw_pkg::REG_EVENTS:       next_rdata[0] = endpoint_sticky_events;
         pepw_pkg::REG_EVENT_ENA:    next_rdata[0] = endpoint_event_enables;
         pepw_pkg::REG_IRQ_IDENT:    next_rdata[0] = cpu_irq_out;
         pepw_pkg::REG_AUX_CFG:      next_rdata[1:0] = aux_cfg;
         pepw_pkg::REG_IRQ_COMMON:   next_rdata[0] = irq_wakeup_disable;
         pepw_pkg::REG_SOFT_RST:     next_rdata[0] = chip_busy;
         default:                    next_rerr = 1'b1;
      endcase
   end
   assign s_axi_arready_out = !s_axi_rvalid_out;
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out  <= 32'h0000_0000;
         s_axi_rresp_out  <= pepw_pkg::AXI_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out  <= next_rdata;
         s_axi_rresp_out  <= next_rerr ? pepw_pkg::AXI_SLVERR :
                                         pepw_pkg::AXI_OKAY;
      end else if (s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
      end
   end
endmodule : pepw_ctrl

// >>> core/pepw_pkg.sv
// Constants for the endpoint power and wake block.
// Assumes a 32-bit AXI4-Lite register bus on one 200 MHz clock.
package pepw_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_XLATE_UPPER  = 8'h00;
   localparam logic [7:0] REG_XLATE_LOWER  = 8'h04;
   localparam logic [7:0] REG_XLATE_CFG2   = 8'h08;
   localparam logic [7:0] REG_PWR_STAT     = 8'h0c;
   localparam logic [7:0] REG_LINK_PCS_CFG = 8'h10;
   localparam logic [7:0] REG_EVENTS       = 8'h14;
   localparam logic [7:0] REG_EVENT_ENA    = 8'h18;
   localparam logic [7:0] REG_IRQ_IDENT    = 8'h1c;
   localparam logic [7:0] REG_AUX_CFG      = 8'h20;
   localparam logic [7:0] REG_IRQ_COMMON   = 8'h24;
   localparam logic [7:0] REG_SOFT_RST     = 8'h28;
   // Field positions
   localparam int XLATE_ENA_BIT   = 0;
   localparam int BEACON_DISABLE_BIT  = 0;
   localparam int WAKE_OUT_POLARITY_BIT    = 1;
   localparam int WAKE_OE_BIT     = 2;
   localparam int PM_EVENT_BIT    = 0;
   localparam int IRQ_WAKE_DIS    = 0;
   localparam int SOFT_CHIP_BIT   = 0;
   // Values and limits
   localparam logic [15:0] XLATE_LOWER_MAX = 16'hc000;
   localparam logic [1:0]  WIN_SEL        = 2'h3;
   localparam logic [1:0]  AUX_FORCE      = 2'h3;
   localparam logic [1:0]  AXI_OKAY       = 2'h0;
   localparam logic [1:0]  AXI_SLVERR     = 2'h2;
   // Power state encodings
   localparam logic [1:0]  PM_D0 = 2'h0;
   localparam logic [1:0]  PM_D1 = 2'h1;
   localparam logic [1:0]  PM_D3 = 2'h3;
   // Soft reset pulse
   localparam int CHIP_RST_NS   = 100;
   localparam int CLK_PERIOD_NS = 5;
   localparam int CHIP_RST_CYC  = (CHIP_RST_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      PEPW_WAKE_IDLE = 2'b00,
      PEPW_WAKE_PEND = 2'b01,
      PEPW_WAKE_SENT = 2'b11
   } pepw_wake_t;
endpackage : pepw_pkg

// >>> core/pepw_reset_pulse.sv
// Stretches a soft reset request into a fixed pulse.
// Assumes the requester is on the same clock.
`timescale 1ns/1ps
module pepw_reset_pulse #(
   parameter int CYCLES = 20
) (
   input  wire logic clk_in,
   input  wire logic srst_in,
   input  wire logic start_in,
   output logic      busy_out
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] count;
   initial begin
      if (CYCLES < 1) $error("CYCLES must be at least one");
   end
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         count    <= '0;
         busy_out <= 1'b0;
      end else if (start_in && !busy_out) begin
         count    <= CW'(CYCLES - 1);
         busy_out <= 1'b1;
      end else if (count != '0) begin
         count <= count - CW'(1);
      end else begin
         busy_out <= 1'b0;
      end
   end
endmodule : pepw_reset_pulse

// >>> core/pepw_sync.sv
// Three-stage synchroniser for off-domain pin levels.
// Output moves only when stages two and three agree.
`timescale 1ns/1ps
module pepw_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         srst_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         meta <= '0;
         s2   <= '0;
         s3   <= '0;
      end else begin
         meta <= async_in;
         s2   <= meta;
         s3   <= s2;
      end
   end
   // Stages two and three must agree
   genvar i;
   for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
         if (srst_in) begin
            sync_out[i] <= 1'b0;
         end else if (s2[i] == s3[i]) begin
            sync_out[i] <= s3[i];
         end
      end
   end
endmodule : pepw_sync

// >>> verif/pepw_ctrl_chk.sv
// Assertions on pepw_ctrl ports.
// Assumes pin changes settle in a few cycles.
`timescale 1ns/1ps
module pepw_ctrl_chk #(
   parameter int RST_CYCLES = 20
) (
   input wire logic        clk_in,
   input wire logic        srst_in,
   input wire logic [31:0] frame_dma_engine_addr_in,
   input wire logic        frame_dma_engine_req_in,
   input wire logic        system_bus_masters_req_in,
   input wire logic [1:0]  outbound_irq_status_in,
   input wire logic [1:0]  outbound_irq_enable_in,
   input wire logic        pme_enable_in,
   input wire logic [1:0]  power_state_field_in,
   input wire logic        s_axi_bvalid_out,
   input wire logic        xlate_hit_out,
   input wire logic [63:0] xlate_addr_out,
   input wire logic        cpu_irq_out,
   input wire logic        pme_request_out,
   input wire logic        beacon_out,
   input wire logic        chip_reset_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   logic [3:0] en_off, d3_off, ps_age;
   logic [1:0] ps_q, st_q;
   logic [2:0] trig_d;
   int         run;
   // Reset clears ages: settling is tolerated
   always_ff @(posedge clk_in) begin
      ps_q <= power_state_field_in;
      st_q <= outbound_irq_status_in;
      if (srst_in) begin
         en_off <= 4'h0;
         d3_off <= 4'h0;
         ps_age <= 4'h0;
         trig_d <= 3'h0;
      end else begin
         en_off <= pme_enable_in ? 4'h0 : en_off + {3'h0, en_off != 4'hf};
         d3_off <= (power_state_field_in == pepw_pkg::PM_D3) ? 4'h0 :
                   d3_off + {3'h0, d3_off != 4'hf};
         ps_age <= (power_state_field_in != ps_q) ? 4'h0 :
                   ps_age + {3'h0, ps_age != 4'hf};
         trig_d <= {trig_d[1:0], frame_dma_engine_req_in |
                    system_bus_masters_req_in |
                    (|((outbound_irq_status_in ^ st_q) &
                       outbound_irq_enable_in))};
      end
   end
   always_ff @(posedge clk_in) begin
      run <= chip_reset_out ? run + 1 : 0;
   end
   a_hit_from_req: assert property (
      xlate_hit_out |-> $past(frame_dma_engine_req_in) &&
         $past(frame_dma_engine_addr_in[31:30]) == 2'h3)
      else $error("hit without request");
   a_hit_low_bits: assert property (
      xlate_hit_out |->
         xlate_addr_out[15:0] == $past(frame_dma_engine_addr_in[15:0]))
      else $error("low bits wrong");
   a_pme_one_pulse: assert property (
      pme_request_out |=> !pme_request_out)
      else $error("pme too long");
   a_pme_needs_en: assert property (
      pme_request_out |-> en_off < 4'h8)
      else $error("pme while disabled");
   a_pme_has_cause: assert property (
      pme_request_out |-> |trig_d[2:1])
      else $error("pme without cause");
   a_chip_rst_len: assert property (
      $fell(chip_reset_out) |-> run == RST_CYCLES)
      else $error("reset length wrong");
   a_irq_has_cause: assert property (
      $rose(cpu_irq_out) |->
         ps_age < 4'hc || s_axi_bvalid_out || $past(s_axi_bvalid_out))
      else $error("irq without cause");
   a_beacon_in_d3: assert property (
      beacon_out |-> d3_off < 4'ha)
      else $error("beacon outside D3");
   c_hit: cover property (xlate_hit_out);
   c_pme: cover property (pme_request_out);
   c_irq: cover property ($rose(cpu_irq_out));
   c_chip_rst: cover property ($fell(chip_reset_out));
endmodule : pepw_ctrl_chk

bind pepw_ctrl pepw_ctrl_chk #(.RST_CYCLES(RST_CYCLES)) u_pepw_ctrl_chk (.*);

// >>> verif/pepw_host_model.sv
// Host model of MAC status pins.
// Assumes bench calls; pins move off clock edges.
`timescale 1ns/1ps
module pepw_host_model (
   output logic [1:0] power_state_field_out,
   output logic       pme_enable_out,
   output logic       mac_reset_out
);
   initial begin
      power_state_field_out = pepw_pkg::PM_D0;
      pme_enable_out = 1'h0;
      mac_reset_out = 1'h0;
   end
   task automatic go_state(input logic [1:0] s);
      #1.7 power_state_field_out = (s == pepw_pkg::PM_D1 ||
                                    s == pepw_pkg::PM_D3) ? s : 2'h0;
   endtask : go_state
   task automatic set_pme(input logic e);
      #1.3 pme_enable_out = e;
   endtask : set_pme
   task automatic set_mac_rst(input logic e);
      #2.1 mac_reset_out = e;
   endtask : set_mac_rst
endmodule : pepw_host_model

// >>> verif/tb_pcie_endpoint_power_wake_ctrl.sv
// Bench for pepw_ctrl: register bus and pins.
// Assumes the host model drives status pins.
`timescale 1ns/1ps
module tb_pcie_endpoint_power_wake_ctrl;
   localparam int RSTC = 6;
   logic clk_in, srst_in = 1'h1;
   logic [7:0] s_axi_awaddr_in = 8'h0, s_axi_araddr_in = 8'h0;
   logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
   logic s_axi_bready_in = 1'h0, s_axi_arvalid_in = 1'h0;
   logic s_axi_rready_in = 1'h0, frame_dma_engine_req_in = 1'h0;
   logic system_bus_masters_req_in = 1'h0, pme_enable_in, mac_reset_in;
   logic [31:0] s_axi_wdata_in = 32'h0, frame_dma_engine_addr_in = 32'h0;
   logic [3:0] s_axi_wstrb_in = 4'hf;
   logic [1:0] outbound_irq_status_in = 2'h0, power_state_field_in;
   logic [1:0] outbound_irq_enable_in = 2'h3, s_axi_bresp_out, s_axi_rresp_out;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic s_axi_arready_out, s_axi_rvalid_out, xlate_hit_out, beacon_out;
   logic aux_power_detect_out, cpu_irq_out, pme_request_out, wake_o_out;
   logic wake_oe_out, chip_reset_out;
   logic [31:0] s_axi_rdata_out;
   logic [63:0] xlate_addr_out;
   int error_cnt = 0, n_checks = 0, cyc = 0, pme_cnt = 0, p;
   pepw_ctrl #(.RST_CYCLES(RSTC)) u_pepw_ctrl (.*);
   pepw_host_model u_pepw_host_model (
      .power_state_field_out(power_state_field_in),
      .pme_enable_out(pme_enable_in), .mac_reset_out(mac_reset_in));
   initial begin
      clk_in = 1'h0;
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic complete_run();
      if (error_cnt == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   // Limit far above the test length
   always @(posedge clk_in) begin
      cyc++;
      if (pme_request_out === 1'h1) pme_cnt++;
      if (cyc == 5000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic [1:0] r);
      if (w) begin
         s_axi_awaddr_in <= a;
         s_axi_wdata_in <= d;
         s_axi_awvalid_in <= 1'h1;
         s_axi_wvalid_in <= 1'h1;
         s_axi_bready_in <= 1'h1;
      end else begin
         s_axi_araddr_in <= a;
         s_axi_arvalid_in <= 1'h1;
         s_axi_rready_in <= 1'h1;
      end
      forever begin
         @(posedge clk_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
         if (w ? s_axi_bvalid_out : s_axi_rvalid_out) begin
            q = s_axi_rdata_out;
            r = w ? s_axi_bresp_out : s_axi_rresp_out;
            s_axi_bready_in <= 1'h0;
            s_axi_rready_in <= 1'h0;
            break;
         end
      end
      @(posedge clk_in);
   endtask : acc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic [1:0]  r;
      acc(1'h1, a, d, q, r);
      cmp(r, pepw_pkg::AXI_OKAY);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      logic [1:0]  r;
      acc(1'h0, a, 32'h0, q, r);
      cmp(q, e);
      cmp(r, pepw_pkg::AXI_OKAY);
   endtask : rd
   task automatic dma(input logic [31:0] a, input logic h,
                      input logic [63:0] e);
      frame_dma_engine_addr_in <= a;
      frame_dma_engine_req_in <= 1'h1;
      @(posedge clk_in);
      frame_dma_engine_req_in <= 1'h0;
      #1 cmp(xlate_hit_out, h);
      if (h) cmp(xlate_addr_out, e);
      @(posedge clk_in);
   endtask : dma
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick
   task automatic bus_req();
      system_bus_masters_req_in <= 1'h1;
      @(posedge clk_in);
      system_bus_masters_req_in <= 1'h0;
      tick(6);
   endtask : bus_req
   initial begin
      logic [31:0] q;
      logic [1:0]  r;
      tick(5);
      srst_in <= 1'h0;
      tick(1);
      rd(pepw_pkg::REG_EVENTS, 32'h0);
      acc(1'h0, 8'h2c, 32'h0, q, r);
      cmp({q, r}, {32'h0, pepw_pkg::AXI_SLVERR});
      acc(1'h1, 8'h06, 32'h1, q, r);
      cmp(r, pepw_pkg::AXI_SLVERR);
      cmp({wake_oe_out, wake_o_out}, 2'h2);
      // DMA idle while window changes
      wr(pepw_pkg::REG_XLATE_UPPER, 32'h1);
      wr(pepw_pkg::REG_XLATE_LOWER, 32'hc000);
      dma(32'hc000_0010, 1'h0, 64'h0);
      wr(pepw_pkg::REG_XLATE_CFG2, 32'h1);
      dma(32'hffff_fffc, 1'h1, 64'h1_ffff_fffc);
      dma(32'hbfff_fffc, 1'h0, 64'h0);
      wr(pepw_pkg::REG_AUX_CFG, 32'h3);
      cmp(aux_power_detect_out, 1'h1);
      wr(pepw_pkg::REG_AUX_CFG, 32'h2);
      cmp(aux_power_detect_out, 1'h0);
      wr(pepw_pkg::REG_EVENT_ENA, 32'h1);
      u_pepw_host_model.go_state(pepw_pkg::PM_D1);
      tick(10);
      rd(pepw_pkg::REG_PWR_STAT, 32'h1);
      rd(pepw_pkg::REG_IRQ_IDENT, 32'h1);
      cmp({cpu_irq_out, chip_reset_out}, 2'h2);
      wr(pepw_pkg::REG_EVENTS, 32'h0);
      rd(pepw_pkg::REG_EVENTS, 32'h1);
      wr(pepw_pkg::REG_EVENTS, 32'h1);
      rd(pepw_pkg::REG_IRQ_IDENT, 32'h0);
      cmp(cpu_irq_out, 1'h0);
      wr(pepw_pkg::REG_EVENT_ENA, 32'h0);
      u_pepw_host_model.go_state(pepw_pkg::PM_D3);
      tick(10);
      rd(pepw_pkg::REG_EVENTS, 32'h1);
      cmp(cpu_irq_out, 1'h0);
      cmp(beacon_out, 1'h1);
      p = pme_cnt;
      bus_req();
      cmp(pme_cnt - p, 64'h0);
      u_pepw_host_model.set_pme(1'h1);
      tick(8);
      bus_req();
      dma(32'h0000_0040, 1'h0, 64'h0);
      tick(4);
      cmp(pme_cnt - p, 64'h1);
      u_pepw_host_model.go_state(pepw_pkg::PM_D0);
      tick(8);
      u_pepw_host_model.go_state(pepw_pkg::PM_D3);
      tick(8);
      wr(pepw_pkg::REG_IRQ_COMMON, 32'h1);
      outbound_irq_status_in <= 2'h1;
      tick(6);
      cmp(pme_cnt - p, 64'h1);
      wr(pepw_pkg::REG_IRQ_COMMON, 32'h0);
      outbound_irq_status_in <= 2'h0;
      tick(6);
      cmp(pme_cnt - p, 64'h2);
      wr(pepw_pkg::REG_LINK_PCS_CFG, 32'h7);
      tick(2);
      cmp({beacon_out, wake_o_out, wake_oe_out}, 3'h1);
      wr(pepw_pkg::REG_LINK_PCS_CFG, 32'h5);
      tick(2);
      cmp({wake_o_out, wake_oe_out}, 2'h3);
      u_pepw_host_model.set_mac_rst(1'h1);
      tick(8);
      u_pepw_host_model.set_mac_rst(1'h0);
      tick(8);
      cmp({wake_o_out, wake_oe_out, chip_reset_out}, 3'h0);
      rd(pepw_pkg::REG_XLATE_UPPER, 32'h1);
      wr(pepw_pkg::REG_SOFT_RST, 32'h1);
      cmp(chip_reset_out, 1'h1);
      while (chip_reset_out === 1'h1) tick(1);
      rd(pepw_pkg::REG_XLATE_UPPER, 32'h0);
      rd(pepw_pkg::REG_EVENTS, 32'h0);
      wr(pepw_pkg::REG_XLATE_UPPER, 32'h1);
      rd(pepw_pkg::REG_XLATE_UPPER, 32'h1);
      complete_run();
   end
endmodule : tb_pcie_endpoint_power_wake_ctrl
